// ---- ssw_supervisor.sv ----
// supply supervisor with watchdog, reset stretching and supply switchover
// assumes comparator flags and decoded strobe arrive from pins, async
`timescale 1ns/100ps
`include "ssw_regs.svh"

// Operation
// - reset low while supply below threshold
// - hold reset 200 ms after recovery
// - strobe silent for timeout gives reset
// - watchdog pulse lasts the same 200 ms
// - any strobe edge restarts timeout count
// - stuck strobe repeats reset every timeout
// - floating strobe disables the watchdog
// - active-high reset is inverse of reset
// - warning low while sense below reference
// - switch to backup, back with margin
// - backup selected holds reset, warn, wdog
module ssw_supervisor
   import ssw_pkg::*;
#(
   parameter int TICK_DIV      = `SSW_TICK_DIV,
   parameter int STRETCH_TICKS = `SSW_STRETCH_TICKS,
   parameter int TIMEOUT_TICKS = `SSW_TIMEOUT_TICKS
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire ssw_comp_t   comp_i,
   input  wire ssw_strobe_t watchdog_strobe_in_i,
   output logic             cpu_reset_n_o,
   output logic             cpu_reset_o,
   output logic             power_fail_warn_n_o,
   output logic             backup_select_o
);

   // counter width; an int count always fits
   localparam int CW = 32;

   // ************************************************************
   // parameter checks
   // ************************************************************
   // refused at elaboration: a zero divider or timeout would wrap the compares and
   // the stretch or the timeout would never end
   if (TICK_DIV < 1 || STRETCH_TICKS < 1 || TIMEOUT_TICKS < 1) begin : g_bad
      $error("ssw_supervisor: counts must be at least one");
   end

   // ************************************************************
   // input synchronisers
   // ************************************************************
   ssw_comp_t   comp_m, comp_s;
   ssw_strobe_t strb_m, strb_s;

   // two stages, first stage read only by the second
   // reset values look like a low supply and a floating strobe, so
   // reset stays held until real samples have come through
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         comp_m <= '{supply_low: 1'b1, default: 1'b0};
         comp_s <= '{supply_low: 1'b1, default: 1'b0};
         strb_m <= '{floating: 1'b1, default: 1'b0};
         strb_s <= '{floating: 1'b1, default: 1'b0};
      end else if (clk_en_i) begin
         comp_m <= comp_i;
         comp_s <= comp_m;
         strb_m <= watchdog_strobe_in_i;
         strb_s <= strb_m;
      end
   end

   // ************************************************************
   // state
   // ************************************************************
   logic [CW-1:0] div_cnt, next_div_cnt;
   logic [CW-1:0] hold_cnt, next_hold_cnt;
   logic [CW-1:0] wd_cnt, next_wd_cnt;
   ssw_state_t    state, next_state;
   logic          backup, next_backup;
   logic          last_level, next_last_level;
   logic          warn_n, next_warn_n;
   logic          tick, wd_enable, wd_edge, wd_expire;

   // ************************************************************
   // supply switchover and warning
   // ************************************************************
   always_comb begin
      next_backup = backup;
      // entry is tested first, so it wins if both flags show at once
      // hysteretic switchover
      if (comp_s.supply_low && comp_s.main_below_backup)
         next_backup = 1'b1;
      else if (comp_s.main_above_backup)
         next_backup = 1'b0;
      // warning from sense, forced low on backup
      // next_backup, not backup: the warning must fall on the same edge
      // as the switchover, or backup would show for a cycle unwarned
      next_warn_n = !(comp_s.sense_low || next_backup);
   end

   // switchover group; clock enable freezes it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         backup <= 1'b0;
         warn_n <= 1'b0;
      end else if (clk_en_i) begin
         backup <= next_backup;
         warn_n <= next_warn_n;
      end
   end

   // ************************************************************
   // time base and watchdog
   // ************************************************************
   // one shared divider, so every interval moves on the same tick
   // tick divider
   assign tick = (div_cnt == CW'(TICK_DIV - 1));
   // counting only in run keeps a pulse from timing itself
   // floating strobe or backup disables watchdog
   assign wd_enable = !strb_s.floating && !backup && (state == SSW_RUN);
   // either edge seen as a level change
   assign wd_edge = (strb_s.high && !last_level) ||
                    (strb_s.low && last_level);
   // expiry sits on the tick grid and may land up to one tick early,
   // inside the tolerance that the timeout allows
   // silent for the timeout, less up to one tick
   assign wd_expire = wd_enable && tick &&
                      (wd_cnt == CW'(TIMEOUT_TICKS - 1)) && !wd_edge;

   always_comb begin
      next_div_cnt = tick ? '0 : div_cnt + CW'(1);
      next_last_level = last_level;
      if (strb_s.high)
         next_last_level = 1'b1;
      else if (strb_s.low)
         next_last_level = 1'b0;
      next_wd_cnt = wd_cnt;
      // restart on edge; count held clear while disabled
      if (!wd_enable || wd_edge || wd_expire)
         next_wd_cnt = '0;
      else if (tick)
         next_wd_cnt = wd_cnt + CW'(1);
   end

   // time base and watchdog group
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt    <= '0;
         wd_cnt     <= '0;
         last_level <= 1'b0; // a held-low strobe gives no edge
      end else if (clk_en_i) begin
         div_cnt    <= next_div_cnt;
         wd_cnt     <= next_wd_cnt;
         last_level <= next_last_level;
      end
   end

   // ************************************************************
   // reset sequencer
   // ************************************************************
   always_comb begin
      next_state    = state;
      next_hold_cnt = hold_cnt;
      unique case (state)
         SSW_HOLD: begin
            next_hold_cnt = '0;
            // stay while supply low or on backup
            if (!comp_s.supply_low && !backup)
               next_state = SSW_STRETCH;
         end
         SSW_STRETCH: begin
            if (comp_s.supply_low || backup) begin
               next_state = SSW_HOLD;
            end else if (tick) begin
               // fixed stretch then release; the first tick
               // comes part way into a period, so one extra tick keeps
               // the pulse no shorter than the full stretch
               if (hold_cnt == CW'(STRETCH_TICKS))
                  next_state = SSW_RUN;
               else
                  next_hold_cnt = hold_cnt + CW'(1);
            end
         end
         SSW_RUN: begin
            next_hold_cnt = '0;
            if (comp_s.supply_low || backup)
               next_state = SSW_HOLD;
            else if (wd_expire)
               next_state = SSW_STRETCH;
         end
         default: begin
            next_state = SSW_HOLD;
         end
      endcase
   end

   // sequencer group; clock enable freezes it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_cnt <= '0;
         state    <= SSW_HOLD;
      end else if (clk_en_i) begin
         hold_cnt <= next_hold_cnt;
         state    <= next_state;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // decoded from the gray state: the only two-bit step leaves run,
   // so the decode cannot glitch high on the way into reset
   // reset low outside run state
   assign cpu_reset_n_o       = (state == SSW_RUN);
   assign cpu_reset_o         = (state != SSW_RUN);
   assign power_fail_warn_n_o = warn_n;
   assign backup_select_o     = backup;

endmodule

// ---- ssw_regs.svh ----
// timing constants for the supply supervisor and watchdog
// assumes a 125 MHz system clock and a 1 kHz internal time base
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH

`define SSW_CLK_HZ        125000000
`define SSW_TICK_HZ       1000
// time base divider, clock cycles per tick
`define SSW_TICK_DIV      (`SSW_CLK_HZ / `SSW_TICK_HZ)
// reset stretch, in ms
`define SSW_STRETCH_MS    200
// watchdog timeout, in ms (1.6 s)
`define SSW_TIMEOUT_MS    1600
`define SSW_STRETCH_TICKS (`SSW_STRETCH_MS * `SSW_TICK_HZ / 1000)
`define SSW_TIMEOUT_TICKS (`SSW_TIMEOUT_MS * `SSW_TICK_HZ / 1000)

`endif

// ---- ssw_pkg.sv ----
// types shared by the supply supervisor and watchdog
// assumes nothing beyond a SystemVerilog compiler
package ssw_pkg;

   // decoded three-level watchdog strobe
   typedef struct packed {
      logic high;
      logic low;
      logic floating;
   } ssw_strobe_t;

   // comparator flags from the analog side
   typedef struct packed {
      logic supply_low;
      logic main_below_backup;
      logic main_above_backup;
      logic sense_low;
   } ssw_comp_t;

   // reset sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      SSW_HOLD    = 2'b00,
      SSW_STRETCH = 2'b01,
      SSW_RUN     = 2'b11
   } ssw_state_t;

endpackage

// ---- ssw_monitor.sv ----
// checker on the supervisor ports
// assumes it is bound to every supervisor
`timescale 1ns/100ps
module ssw_monitor
   import ssw_pkg::*;
#(parameter int TICK_DIV = 4, parameter int STRETCH_TICKS = 3,
   parameter int TIMEOUT_TICKS = 8) (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        clk_en_i,
   input wire ssw_comp_t   comp_i,
   input wire ssw_strobe_t watchdog_strobe_in_i,
   input wire logic        cpu_reset_n_o,
   input wire logic        cpu_reset_o,
   input wire logic        power_fail_warn_n_o,
   input wire logic        backup_select_o
);
   // ****
   // helper counts
   // ****
   localparam int TO = TIMEOUT_TICKS * TICK_DIV;
   localparam int ST = STRETCH_TICKS * TICK_DIV;
   int         q;
   int         cl;
   logic [2:0] sr;
   // quiet strobe time and stretch time; slack covers the tick phase
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i) begin
         q  <= 0;
         cl <= 0;
         sr <= 3'h7;
      end else if (clk_en_i) begin
         q  <= (!cpu_reset_n_o || backup_select_o ||
            watchdog_strobe_in_i.floating ||
            watchdog_strobe_in_i != $past(watchdog_strobe_in_i)) ? 0 : q + 1;
         cl <= (cpu_reset_n_o || |sr || backup_select_o) ? 0 : cl + 1;
         sr <= {sr[1:0], comp_i.supply_low};
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   supply_low_a : assert property ((clk_en_i && comp_i.supply_low)[*3]
      |=> !cpu_reset_n_o) else $error("reset not low on low supply");
   warn_low_a : assert property ((clk_en_i && comp_i.sense_low)[*3]
      |=> !power_fail_warn_n_o) else $error("warning not low");
   to_backup_a : assert property ((clk_en_i && comp_i.supply_low
      && comp_i.main_below_backup)[*3] |=> backup_select_o)
      else $error("no switch to backup");
   backup_hold_a : assert property (backup_select_o |->
      !cpu_reset_n_o && !power_fail_warn_n_o) else $error("backup not held");
   stretch_min_a : assert property ($rose(cpu_reset_n_o) |->
      !$past(cpu_reset_n_o, ST)) else $error("reset released early");
   stretch_max_a : assert property (cl <= ST + TICK_DIV + 4)
      else $error("reset held too long");
   wdog_fire_a : assert property (q <= TO + TICK_DIV + 4)
      else $error("watchdog did not fire");
   wdog_early_a : assert property ($fell(cpu_reset_n_o) && !(|sr) &&
      !backup_select_o |-> q >= TO - TICK_DIV) else $error("early pulse");
   cover property ($fell(cpu_reset_n_o) && !(|sr));
   cover property ($rose(backup_select_o));
   cover property ($fell(power_fail_warn_n_o));
endmodule
bind ssw_supervisor ssw_monitor #(.TICK_DIV(TICK_DIV),
   .STRETCH_TICKS(STRETCH_TICKS), .TIMEOUT_TICKS(TIMEOUT_TICKS))
   ssw_monitor_i (.*);

// ---- ssw_cpu_model.sv ----
// processor model driving the watchdog strobe
// assumes the bench changes mode at falling edges
`timescale 1ns/100ps
module ssw_cpu_model
   import ssw_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       cpu_reset_n_i,
   input  wire logic [1:0] mode_i,
   output ssw_strobe_t     strobe_o
);
   logic lvl = 1'b0;
   int   n = 0;
   // kick every 20 cycles; mode 1 sticks, mode 2 floats
   always @(negedge clk_i) begin
      n <= (cpu_reset_n_i && n < 19) ? n + 1 : 0;
      if (cpu_reset_n_i && n == 18 && mode_i == 2'h0)
         lvl <= !lvl;
   end
   // decoded strobe: floating in mode 2, else the held level
   assign strobe_o = (mode_i == 2'h2) ? 3'h1 : {lvl, !lvl, 1'b0};
endmodule

// ---- ssw_supervisor_bench.sv ----
// self-checking bench for the supervisor
// assumes small counts: tick 4, stretch 3, timeout 8
`timescale 1ns/100ps
module ssw_supervisor_bench;
   import ssw_pkg::*;
   logic        clk_i = 0;
   logic        reset_n_i = 0;
   ssw_comp_t   comp_i = '0;
   ssw_strobe_t stb;
   logic [1:0]  mode = 2'h0;
   logic        clk_en = 1'b1;
   logic        rst_n, rst, warn_n, bsel;
   logic [2:0]  exp_q[$];
   logic [2:0]  last = 3'h0;
   int          errors = 0;
   int          n_checks = 0;
   always #4 clk_i = !clk_i;
   ssw_supervisor #(.TICK_DIV(4), .STRETCH_TICKS(3), .TIMEOUT_TICKS(8))
      ssw_supervisor_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .clk_en_i(clk_en), .comp_i(comp_i), .watchdog_strobe_in_i(stb),
      .cpu_reset_n_o(rst_n), .cpu_reset_o(rst),
      .power_fail_warn_n_o(warn_n), .backup_select_o(bsel));
   ssw_cpu_model ssw_cpu_model_i (.clk_i(clk_i), .cpu_reset_n_i(rst_n),
      .mode_i(mode), .strobe_o(stb));
   // ****
   // checking
   // ****
   task automatic chk(string what, logic [2:0] e, logic [2:0] s);
      n_checks++;
      if (e !== s) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   // each change of {reset_n, warn_n, backup} takes the oldest note
   always @(negedge clk_i) begin
      if ({rst_n, warn_n, bsel} !== last) begin
         chk("outputs", exp_q.size() ? exp_q.pop_front() : last,
            {rst_n, warn_n, bsel});
         chk("reset_high", {2'h0, !rst_n}, {2'h0, rst});
         last = {rst_n, warn_n, bsel};
      end
   end
   task automatic cyc(int n);
      repeat (n) @(negedge clk_i);
   endtask
   // bounded wait for notes, then a quiet spell longer than the timeout
   task automatic drain(string name);
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) cyc(1);
      mode = 2'h0;
      cyc(60);
      chk("pending", 3'h0, 3'(exp_q.size()));
      $display("test %s done", name);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hFB4B992F));
      cyc(20);
      reset_n_i = 1;
      exp_q = '{3'h2, 3'h6};
      drain("startup");
      comp_i.sense_low = 1;
      exp_q = '{3'h4, 3'h6};
      cyc($urandom_range(12, 3));
      comp_i.sense_low = 0;
      drain("warning");
      comp_i.supply_low = 1;
      exp_q = '{3'h2, 3'h6};
      cyc($urandom_range(40, 3));
      comp_i.supply_low = 0;
      drain("supply");
      mode = 2'h1;
      exp_q = '{3'h2, 3'h6, 3'h2, 3'h6};
      drain("stuck");
      mode = 2'h2;
      cyc(150);
      drain("floating");
      // frozen by the clock enable, a low supply must go unseen
      clk_en = 0;
      comp_i.supply_low = 1;
      cyc($urandom_range(80, 10));
      comp_i.supply_low = 0;
      clk_en = 1;
      drain("freeze");
      comp_i = 4'hC;
      exp_q = '{3'h1};
      cyc(100);
      comp_i = 4'h2;
      exp_q = '{3'h2, 3'h6};
      drain("backup");
      tally_and_finish;
   end
   // cut a hang well past the expected run of some 1000 cycles
   initial begin
      #48000;
      errors++;
      tally_and_finish;
   end
endmodule
